// >>> inc/llm_defs.svh
// Register map, field positions and widths of the latency measurement readout
`ifndef LLM_DEFS_SVH
`define LLM_DEFS_SVH
`define LLM_ADDR_W     5
`define LLM_DATA_W     16
`define LLM_ADDR_CTRL  5'h10
`define LLM_ADDR_UPPER 5'h11
`define LLM_ADDR_LOWER 5'h12
`define LLM_REG_ZERO   16'h0000
`define LLM_CNT_W      20
`define LLM_LOW_W      16
`define LLM_CNT_ZERO   20'h00000
`define LLM_CNT_ONE    20'h00001
`define LLM_CNT_MAX    20'hFFFFF
`define LLM_BIT_TX     15
`define LLM_BIT_RX     14
`define LLM_BIT_DONE   4
`define LLM_BIT_CH     0
`define LLM_BIT_EN     1
`define LLM_BIT_CLK    2
`define LLM_DIV_LO     4
`define LLM_DIV_HI     5
`define LLM_HALF_UP    1
`define LLM_DIV_W      3
`define LLM_DIV_ZERO   3'h0
`define LLM_DIV_ONE    3'h1
`define LLM_MASK_D1    3'h0
`define LLM_MASK_D2    3'h1
`define LLM_MASK_D4    3'h3
`define LLM_MASK_D8    3'h7
`endif

// >>> inc/llm_pkg.sv
// Types shared by the latency measurement readout modules
`include "llm_defs.svh"
package llm_pkg;
  // Register access request from the management controller
  typedef struct packed {
    logic                   rd;
    logic                   wr;
    logic [`LLM_ADDR_W-1:0] addr;
    logic [`LLM_DATA_W-1:0] wdata;
  } llm_req_s;
  // Comma hits on one channel: bit 1 upper ten bits, bit 0 lower ten bits
  typedef struct packed {
    logic [1:0] tx;
    logic [1:0] rx;
  } llm_comma_s;
  // Measurement control fields
  typedef struct packed {
    logic [1:0] measure_clock_divider;
    logic       measure_clock_source;
    logic       measure_enable_bit;
    logic       measure_channel_select;
  } llm_ctrl_s;
  typedef enum logic [1:0] {MS_IDLE, MS_COUNT, MS_DONE} llm_state_e;
endpackage : llm_pkg

// >>> rtl/llm_tick_gen.sv
// Count enable generator: divided reference or recovered byte clock edges
`timescale 1ns/1ps
`include "llm_defs.svh"
module llm_tick_gen (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       clk_src,
  input  wire logic [1:0] clk_div,
  input  wire logic       chan_sel,
  input  wire logic [1:0] byte_clk,
  output logic            tick
);
  logic [1:0]             sync1_q, sync2_q, sync3_q;
  logic [`LLM_DIV_W-1:0]  div_cnt_q, div_cnt_d, mask;
  logic                   tick_q, tick_d;

  // Two-stage synchronisers plus an edge stage, one per channel
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        sync1_q[i] <= 1'b0;
        sync2_q[i] <= 1'b0;
        sync3_q[i] <= 1'b0;
      end else begin
        sync1_q[i] <= byte_clk[i];
        sync2_q[i] <= sync1_q[i];
        sync3_q[i] <= sync2_q[i];
      end
    end
  end

  // Divider mask and next tick
  always_comb begin
    case (clk_div)
      2'b00:   mask = `LLM_MASK_D1;  // R15
      2'b01:   mask = `LLM_MASK_D2;
      2'b10:   mask = `LLM_MASK_D4;
      default: mask = `LLM_MASK_D8;
    endcase
    div_cnt_d = div_cnt_q + `LLM_DIV_ONE;
    if (clk_src) begin
      tick_d = sync2_q[chan_sel] & ~sync3_q[chan_sel];  // R14
    end else begin
      tick_d = (div_cnt_q & mask) == mask;  // R15
    end
  end

  // Divider counter and tick register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt_q <= `LLM_DIV_ZERO;
      tick_q    <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_d;
      tick_q    <= tick_d;
    end
  end

  assign tick = tick_q;

  property p_div_eight;
    @(posedge ref_clk) disable iff (!resetn)
    (!clk_src && clk_div == 2'b11) |=> (tick_q == ($past(div_cnt_q) == `LLM_MASK_D8));
  endproperty
  a_div_eight: assert property (p_div_eight) else $error("divide by 8 tick misplaced"); // R15
endmodule : llm_tick_gen

// >>> rtl/llm_readout.sv
// Latency measurement counter with clear-on-read result registers
`timescale 1ns/1ps
`include "llm_defs.svh"
// Overview of operation
// (R1) The transmit comma flag shows 0 when the comma was in the upper ten bits, 1 when lower.
// (R2) The receive comma flag shows 0 when the comma was in the upper ten bits, 1 when lower.
// (R3) Both comma flags are read-only and hold their value until the clearing read; a disable during counting also clears the transmit flag.
// (R4) The done flag is 1 once a measurement has finished and 0 while it is incomplete.
// (R5) The count is 20 bits: bits 19:16 in the upper register, bits 15:0 in the lower one.
// (R6) The count is a whole number of ticks of the selected measurement clock.
// (R7) Before a receive comma has been seen the count reads as zero.
// (R8) The count saturates at all ones instead of wrapping.
// (R9) The host reads the upper result register before the lower one.
// (R10) Reading the lower result register resets the count to zero.
// (R11) The same read clears both comma flags and the done flag.
// (R12) Measurement runs only while the enable bit is 1, which resets to 0.
// (R13) The channel select picks channel A at 0 (reset) and channel B at 1.
// (R14) The clock source picks the divided reference at 0 and the recovered byte clock at 1.
// (R15) The divider code 00/01/10/11 divides the reference tick by 1/2/4/8.
// (R16) Counting starts at the transmit comma and stops at the receive comma, then done is set.
module llm_readout (
  input  wire logic                   ref_clk,
  input  wire logic                   resetn,
  input  wire llm_pkg::llm_req_s      reg_req,
  output logic [`LLM_DATA_W-1:0]      reg_rdata,
  output logic                        reg_rvalid,
  input  wire llm_pkg::llm_comma_s    comma_a,
  input  wire llm_pkg::llm_comma_s    comma_b,
  input  wire logic                   byte_clk_a,
  input  wire logic                   byte_clk_b,
  output logic                        measure_done_flag
);
  import llm_pkg::*;

  llm_state_e                 state_q, state_d;
  logic [`LLM_CNT_W-1:0]      cnt_q, cnt_d, vis_cnt;
  logic                       tx_flag_q, tx_flag_d, rx_flag_q, rx_flag_d;
  logic [`LLM_LOW_W-1:0]      shadow_q, shadow_d;
  llm_ctrl_s                  ctrl_q, ctrl_d;
  logic [`LLM_DATA_W-1:0]     rdata_q, rdata_d, upper_val, ctrl_val;
  logic                       rvalid_q, rvalid_d;
  llm_comma_s                 sel;
  logic                       tx_hit, rx_hit, tx_half, rx_half;
  logic                       rd_upper, rd_lower, tick;

  // Lane flag from a pair of half hits; the upper half wins a tie
  function automatic logic half_flag(input logic [1:0] hits);
    return ~hits[`LLM_HALF_UP];
  endfunction : half_flag

  // Tick source for the counter
  llm_tick_gen u_tick (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .clk_src  (ctrl_q.measure_clock_source),
    .clk_div  (ctrl_q.measure_clock_divider),
    .chan_sel (ctrl_q.measure_channel_select),
    .byte_clk ({byte_clk_b, byte_clk_a}),
    .tick     (tick)
  );

  // Channel selection and access decode
  always_comb begin
    sel      = ctrl_q.measure_channel_select ? comma_b : comma_a;  // R13
    tx_hit   = |sel.tx;
    rx_hit   = |sel.rx;
    tx_half  = half_flag(sel.tx);  // R1
    rx_half  = half_flag(sel.rx);  // R2
    rd_upper = reg_req.rd && (reg_req.addr == `LLM_ADDR_UPPER);
    rd_lower = reg_req.rd && (reg_req.addr == `LLM_ADDR_LOWER);
  end

  // Measurement state, counter and flags
  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    tx_flag_d = tx_flag_q;
    rx_flag_d = rx_flag_q;
    case (state_q)
      MS_IDLE: begin
        if (ctrl_q.measure_enable_bit && tx_hit) begin  // R12
          state_d   = MS_COUNT;  // R16
          cnt_d     = `LLM_CNT_ZERO;
          tx_flag_d = tx_half;  // R1
          rx_flag_d = 1'b0;
        end else if (rd_lower) begin
          cnt_d     = `LLM_CNT_ZERO;  // R10
          tx_flag_d = 1'b0;  // R11
          rx_flag_d = 1'b0;
        end
      end
      MS_COUNT: begin
        if (!ctrl_q.measure_enable_bit) begin
          state_d   = MS_IDLE;  // R12
          cnt_d     = `LLM_CNT_ZERO;
          tx_flag_d = 1'b0;
        end else if (rx_hit) begin
          state_d   = MS_DONE;  // R16
          rx_flag_d = rx_half;  // R2
        end else if (rd_lower) begin
          state_d   = MS_IDLE;
          cnt_d     = `LLM_CNT_ZERO;  // R10
          tx_flag_d = 1'b0;  // R11
        end else if (tick && (cnt_q != `LLM_CNT_MAX)) begin  // R8
          cnt_d = cnt_q + `LLM_CNT_ONE;  // R6
        end
      end
      MS_DONE: begin
        if (rd_lower) begin
          state_d   = MS_IDLE;  // R11
          cnt_d     = `LLM_CNT_ZERO;  // R10
          tx_flag_d = 1'b0;  // R11
          rx_flag_d = 1'b0;
        end
      end
      default: state_d = MS_IDLE;
    endcase
  end

  // Measurement registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q   <= MS_IDLE;
      cnt_q     <= `LLM_CNT_ZERO;
      tx_flag_q <= 1'b0;
      rx_flag_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      tx_flag_q <= tx_flag_d;  // R3
      rx_flag_q <= rx_flag_d;  // R3
    end
  end

  // Register images and read path
  always_comb begin
    vis_cnt   = (state_q == MS_DONE) ? cnt_q : `LLM_CNT_ZERO;  // R7
    upper_val = `LLM_REG_ZERO;
    upper_val[`LLM_BIT_TX]   = tx_flag_q;
    upper_val[`LLM_BIT_RX]   = rx_flag_q;
    upper_val[`LLM_BIT_DONE] = (state_q == MS_DONE);  // R4
    upper_val[`LLM_CNT_W-`LLM_LOW_W-1:0] = vis_cnt[`LLM_CNT_W-1:`LLM_LOW_W];  // R5
    ctrl_val  = `LLM_REG_ZERO;
    ctrl_val[`LLM_DIV_HI:`LLM_DIV_LO] = ctrl_q.measure_clock_divider;
    ctrl_val[`LLM_BIT_CLK] = ctrl_q.measure_clock_source;
    ctrl_val[`LLM_BIT_EN]  = ctrl_q.measure_enable_bit;
    ctrl_val[`LLM_BIT_CH]  = ctrl_q.measure_channel_select;
    shadow_d  = rd_upper ? vis_cnt[`LLM_LOW_W-1:0] : shadow_q;  // R9
    rvalid_d  = reg_req.rd;
    rdata_d   = rdata_q;
    if (reg_req.rd) begin
      case (reg_req.addr)
        `LLM_ADDR_CTRL:  rdata_d = ctrl_val;
        `LLM_ADDR_UPPER: rdata_d = upper_val;
        `LLM_ADDR_LOWER: rdata_d = shadow_q;  // R5
        default:         rdata_d = `LLM_REG_ZERO;
      endcase
    end
    ctrl_d = ctrl_q;
    if (reg_req.wr && (reg_req.addr == `LLM_ADDR_CTRL)) begin
      ctrl_d.measure_clock_divider  = reg_req.wdata[`LLM_DIV_HI:`LLM_DIV_LO];  // R15
      ctrl_d.measure_clock_source   = reg_req.wdata[`LLM_BIT_CLK];  // R14
      ctrl_d.measure_enable_bit     = reg_req.wdata[`LLM_BIT_EN];  // R12
      ctrl_d.measure_channel_select = reg_req.wdata[`LLM_BIT_CH];  // R13
    end
  end

  // Register file and read data
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      shadow_q <= `LLM_REG_ZERO;
      rdata_q  <= `LLM_REG_ZERO;
      rvalid_q <= 1'b0;
      ctrl_q   <= '0;
    end else begin
      shadow_q <= shadow_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
      ctrl_q   <= ctrl_d;
    end
  end

  assign reg_rdata         = rdata_q;
  assign reg_rvalid        = rvalid_q;
  assign measure_done_flag = (state_q == MS_DONE);  // R4

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_armed;
    state_q == MS_IDLE && ctrl_q.measure_enable_bit && tx_hit;
  endsequence
  sequence s_finish;
    state_q == MS_COUNT && ctrl_q.measure_enable_bit && rx_hit;
  endsequence

  property p_tx_lane;
    s_armed |=> (tx_flag_q == $past(tx_half)) && state_q == MS_COUNT;
  endproperty
  a_tx_lane: assert property (p_tx_lane) else $error("tx lane flag wrong"); // R1
  property p_rx_lane;
    s_finish |=> (rx_flag_q == $past(rx_half)) && measure_done_flag;
  endproperty
  a_rx_lane: assert property (p_rx_lane) else $error("rx lane flag wrong"); // R2
  property p_flags_hold;
    (measure_done_flag && !rd_lower) |=> $stable(tx_flag_q) && $stable(rx_flag_q)
      && $stable(cnt_q) && measure_done_flag;
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("result not held"); // R3
  property p_zero_early;
    (rd_upper && !measure_done_flag) |=> reg_rvalid && reg_rdata[`LLM_BIT_DONE] == 1'b0
      && reg_rdata[3:0] == 4'h0;
  endproperty
  a_zero_early: assert property (p_zero_early) else $error("count not zero"); // R7
  property p_saturate;
    (state_q == MS_COUNT && cnt_q == `LLM_CNT_MAX && ctrl_q.measure_enable_bit && !rd_lower)
      |=> cnt_q == `LLM_CNT_MAX;
  endproperty
  a_saturate: assert property (p_saturate) else $error("counter wrapped"); // R8
  property p_step;
    (state_q == MS_COUNT && ctrl_q.measure_enable_bit && !rx_hit && !rd_lower && tick
      && cnt_q != `LLM_CNT_MAX) |=> cnt_q == $past(cnt_q) + `LLM_CNT_ONE;
  endproperty
  a_step: assert property (p_step) else $error("count step missed"); // R6
  property p_clear_read;
    (measure_done_flag && rd_lower) |=> cnt_q == `LLM_CNT_ZERO && !tx_flag_q && !rx_flag_q
      && !measure_done_flag;
  endproperty
  a_clear_read: assert property (p_clear_read) else $error("read did not clear"); // R10
  property p_disable;
    (state_q == MS_COUNT && !ctrl_q.measure_enable_bit) |=> state_q == MS_IDLE ##1
      (state_q == MS_IDLE || ctrl_q.measure_enable_bit);
  endproperty
  a_disable: assert property (p_disable) else $error("ran while disabled"); // R12
  property p_chan_b;
    (state_q == MS_IDLE && ctrl_q.measure_enable_bit && ctrl_q.measure_channel_select
      && comma_b.tx == 2'b00) |=> state_q == MS_IDLE;
  endproperty
  a_chan_b: assert property (p_chan_b) else $error("wrong channel started"); // R13
endmodule : llm_readout

// >>> tb/llm_host_model.sv
// Management host model that drives the register request port
`timescale 1ns/1ps
`include "llm_defs.svh"
module llm_host_model (
  input  wire logic                   ref_clk,
  output llm_pkg::llm_req_s           req,
  input  wire logic [`LLM_DATA_W-1:0] rdata,
  input  wire logic                   rvalid
);
  import llm_pkg::*;

  // Bus idle from time zero
  initial req = '0;

  // One access: request for one edge, answer taken at the next falling edge
  task automatic access(input logic is_wr, input logic [`LLM_ADDR_W-1:0] addr,
                        input logic [`LLM_DATA_W-1:0] wdata, output logic [16:0] resp);
    @(negedge ref_clk);
    req = '{rd: !is_wr, wr: is_wr, addr: addr, wdata: wdata};
    @(negedge ref_clk);
    resp = {rvalid, rdata};
    // Released lines show the inverse so stale values are never trusted
    req = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
  endtask : access

  task automatic rd(input logic [`LLM_ADDR_W-1:0] addr, output logic [16:0] resp);
    access(1'b0, addr, `LLM_REG_ZERO, resp);
  endtask : rd

  task automatic wr(input logic [`LLM_ADDR_W-1:0] addr, input logic [`LLM_DATA_W-1:0] data);
    logic [16:0] unused;
    access(1'b1, addr, data, unused);
  endtask : wr

  // Result pair always fetched upper first
  task automatic rd_pair(output logic [16:0] hi, output logic [16:0] lo);
    rd(`LLM_ADDR_UPPER, hi);
    rd(`LLM_ADDR_LOWER, lo);
  endtask : rd_pair
endmodule : llm_host_model

// >>> tb/testbench.sv
// Self-checking bench for the latency measurement readout
`timescale 1ns/1ps
`include "llm_defs.svh"
module testbench;
  import llm_pkg::*;
  logic        ref_clk;
  logic        resetn;
  llm_req_s    reg_req;
  logic [15:0] reg_rdata;
  logic        reg_rvalid;
  llm_comma_s  comma_a;
  llm_comma_s  comma_b;
  logic        byte_clk;
  logic        measure_done_flag;
  int          fails;
  int          check_count;
  logic [16:0] hi;
  logic [16:0] lo;
  logic [19:0] c1;
  logic [19:0] c2;

  // Reference clock and a slow recovered byte clock of 16 reference cycles
  initial ref_clk = 1'b0;
  always #12.5 ref_clk = ~ref_clk;
  initial byte_clk = 1'b0;
  always #200 byte_clk = ~byte_clk;

  llm_readout u_llm_readout (.ref_clk(ref_clk), .resetn(resetn), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .comma_a(comma_a), .comma_b(comma_b),
    .byte_clk_a(byte_clk), .byte_clk_b(byte_clk), .measure_done_flag(measure_done_flag));

  llm_host_model u_llm_host_model (.ref_clk(ref_clk), .req(reg_req), .rdata(reg_rdata),
    .rvalid(reg_rvalid));

  task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic wait_n(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : wait_n

  // One measurement; the unselected channel carries a receive comma as bait
  task automatic measure(input logic ch, input int n, input logic [1:0] txc,
                         input logic [1:0] rxc, output logic [19:0] cnt);
    llm_comma_s hit;
    llm_comma_s bait;
    // Start one falling edge past the byte clock edge so every span starts at one phase
    @(posedge byte_clk);
    #5;
    @(negedge ref_clk);
    hit = '{tx: txc, rx: 2'b00};
    bait = '{tx: 2'b00, rx: 2'b11};
    {comma_b, comma_a} = ch ? {hit, bait} : {bait, hit};
    @(negedge ref_clk);
    hit.tx = 2'b00;
    {comma_b, comma_a} = ch ? {hit, bait} : {bait, hit};
    wait_n(n - 1);
    check("done_busy", {19'h0, measure_done_flag}, 20'h00000);
    hit.rx = rxc;
    {comma_b, comma_a} = ch ? {hit, bait} : {bait, hit};
    @(negedge ref_clk);
    comma_a = '0;
    comma_b = '0;
    wait_n(2);
    check("done_flag", {19'h0, measure_done_flag}, 20'h00001);
    u_llm_host_model.rd_pair(hi, lo);
    check("upper", {3'h0, hi}, {3'h0, 1'b1, txc == 2'b01, rxc == 2'b01, 10'h001, 4'h0});
    check("lower_valid", {19'h0, lo[16]}, 20'h00001);
    cnt = {hi[3:0], lo[15:0]};
    check("done_cleared", {19'h0, measure_done_flag}, 20'h00000);
    u_llm_host_model.rd_pair(hi, lo);
    check("upper_cleared", {4'h0, hi[15:0]}, 20'h00000);
    check("lower_cleared", {4'h0, lo[15:0]}, 20'h00000);
  endtask : measure

  // Main sequence
  initial begin
    fails = 0;
    check_count = 0;
    resetn = 1'b0;
    comma_a = '0;
    comma_b = '0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    resetn = 1'b1;
    u_llm_host_model.rd(`LLM_ADDR_CTRL, hi);
    check("ctrl_reset", {3'h0, hi}, 20'h10000);
    u_llm_host_model.rd_pair(hi, lo);
    check("upper_reset", {3'h0, hi}, 20'h10000);
    check("lower_reset", {3'h0, lo}, 20'h10000);
    u_llm_host_model.rd(5'h1F, hi);
    check("unmapped", {3'h0, hi}, 20'h10000);
    u_llm_host_model.wr(`LLM_ADDR_CTRL, 16'hFFFF);
    u_llm_host_model.rd(`LLM_ADDR_CTRL, hi);
    check("ctrl_rw", {3'h0, hi}, 20'h10037);
    // Disabled: commas must not start a measurement
    u_llm_host_model.wr(`LLM_ADDR_CTRL, `LLM_REG_ZERO);
    comma_a = 4'b0100;
    wait_n(3);
    comma_a = 4'b0001;
    wait_n(3);
    comma_a = '0;
    wait_n(2);
    check("done_disabled", {19'h0, measure_done_flag}, 20'h00000);
    // Each divider code, channel alternating; span difference is exact
    for (int code = 0; code < 4; code++) begin
      u_llm_host_model.wr(`LLM_ADDR_CTRL, 16'(code * 16 + 2 + code % 2));
      measure(1'(code % 2), 16, 2'b01, 2'b10, c1);
      measure(1'(code % 2), 48, 2'b10, 2'b01, c2);
      if (code == 0) begin
        check("div1_count", c1, 20'h0000F);
      end
      check("div_span", c2 - c1, 20'(32 >> code));
    end
    // Recovered byte clock: 64 more cycles hold 4 more rising byte clock edges
    u_llm_host_model.wr(`LLM_ADDR_CTRL, 16'h0006);
    measure(1'b0, 32, 2'b01, 2'b01, c1);
    measure(1'b0, 96, 2'b10, 2'b10, c2);
    check("byte_span", c2 - c1, 20'h00004);
    // Read while still waiting for the receive comma
    u_llm_host_model.wr(`LLM_ADDR_CTRL, 16'h0002);
    comma_a = 4'b0100;
    wait_n(1);
    comma_a = '0;
    wait_n(10);
    u_llm_host_model.rd_pair(hi, lo);
    check("early_upper", {15'h0, hi[4:0]}, 20'h00000);
    check("early_lower", {4'h0, lo[15:0]}, 20'h00000);
    check("early_tx", {19'h0, hi[15]}, 20'h00001);
    // Disable while counting aborts the measurement and drops the lane flag
    comma_a = 4'b0100;
    wait_n(1);
    comma_a = '0;
    wait_n(3);
    u_llm_host_model.rd(`LLM_ADDR_UPPER, hi);
    check("abort_armed", {19'h0, hi[15]}, 20'h00001);
    u_llm_host_model.wr(`LLM_ADDR_CTRL, `LLM_REG_ZERO);
    wait_n(2);
    check("abort_done", {19'h0, measure_done_flag}, 20'h00000);
    u_llm_host_model.rd(`LLM_ADDR_UPPER, hi);
    check("abort_upper", {4'h0, hi[15:0]}, 20'h00000);
    close_out();
  end

  // Watchdog at 8000 cycles, well beyond the under one thousand cycles the tests need
  initial begin
    #200000;
    fails++;
    close_out();
  end
endmodule : testbench
